// ---- hdl/stream_aux_framing_config.sv ----
// axi4-lite register bank for stream mode and auxiliary framing settings
// assumes one clock, synchronous active-low reset and a master that holds
// valid and payload until ready
`timescale 1ns/1ps
`include "stream_aux_framing_map.svh"
module stream_aux_framing_config
  import stream_aux_framing_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic set_default,
  input wire logic analog_preset,
  input wire logic preset_am,
  input wire framing_ctx_type ctx,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output stream_cfg_type stream_cfg,
  output aux_cfg_type aux_cfg,
  output logic [4:0] subcarrier_div_log2,
  output logic [3:0] report_pulses,
  output logic [7:0] tx_period_div,
  output logic rx_skip_crc,
  output logic crc_to_fifo,
  output logic rf_output_driver_hiz
);
  logic [7:0] stream_q;
  logic [7:0] aux_q;
  logic [7:0] aw_q;
  logic aw_have_q;
  logic [31:0] w_q;
  logic w_strb0_q;
  logic w_have_q;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic wr_strb0;
  logic wr_fire;
  logic [7:0] rd_val;
  logic rd_hit;

  // accept each write channel once, hold until the response is taken
  assign awready = clk_en && !aw_have_q && !bvalid;
  assign wready = clk_en && !w_have_q && !bvalid;
  assign arready = clk_en && !rvalid;
  assign wr_addr = aw_have_q ? aw_q : awaddr;
  assign wr_data = w_have_q ? w_q : wdata;
  assign wr_strb0 = w_have_q ? w_strb0_q : wstrb[0];
  assign wr_fire = clk_en && !bvalid && (aw_have_q || awvalid)
    && (w_have_q || wvalid);

  // capture address and data in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_q <= 8'h00;
      aw_have_q <= 1'b0;
      w_q <= 32'h0;
      w_strb0_q <= 1'b0;
      w_have_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (wr_fire)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
      end
      else
      begin
        if (awvalid && awready)
        begin
          aw_q <= awaddr;
          aw_have_q <= 1'b1;
        end
        if (wvalid && wready)
        begin
          w_q <= wdata;
          w_strb0_q <= wstrb[0];
          w_have_q <= 1'b1;
        end
      end
    end
  end

  // write response, slverr on unmapped address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp <= resp_okay;
    end
    else if (clk_en)
    begin
      if (wr_fire)
      begin
        bvalid <= 1'b1;
        bresp <= (wr_addr == `STREAM_MODE_ADDR
          || wr_addr == `AUX_DEF_ADDR) ? resp_okay
          : resp_slverr;
      end
      else if (bready)
      begin
        bvalid <= 1'b0;
      end
    end
  end

  // stream mode register; bit 7 reserved, reads zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn || (clk_en && set_default))
    begin
      stream_q <= `STREAM_MODE_RESET;
    end
    else if (clk_en && wr_fire && wr_strb0
      && wr_addr == `STREAM_MODE_ADDR)
    begin
      stream_q <= {1'b0, wr_data[6:0]};
    end
  end

  // auxiliary register; set-default first, then write, then preset
  always_ff @(posedge aclk)
  begin
    if (!aresetn || (clk_en && set_default))
    begin
      aux_q <= `AUX_DEF_RESET;
    end
    else if (clk_en)
    begin
      if (wr_fire && wr_strb0 && wr_addr == `AUX_DEF_ADDR)
      begin
        aux_q <= wr_data[7:0];
      end
      else if (analog_preset)
      begin
        aux_q[`MOD_AM_BIT] <= preset_am;
      end
    end
  end

  // read decode
  always_comb
  begin
    rd_hit = 1'b1;
    case (araddr)
      `STREAM_MODE_ADDR: rd_val = stream_q;
      `AUX_DEF_ADDR: rd_val = aux_q;
      default:
      begin
        rd_val = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  // read channel, one cycle after acceptance
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= resp_okay;
    end
    else if (clk_en)
    begin
      if (arvalid && arready)
      begin
        rvalid <= 1'b1;
        rdata <= {24'h0, rd_val};
        rresp <= rd_hit ? resp_okay : resp_slverr;
      end
      else if (rready)
      begin
        rvalid <= 1'b0;
      end
    end
  end

  // field views
  always_comb
  begin
    stream_cfg.subcarrier_freq_sel = stream_q[`SCF_LSB +: 2];
    stream_cfg.report_pulse_count = stream_q[`SCP_LSB +: 2];
    stream_cfg.tx_period_sel = stream_q[`STX_LSB +: 3];
    aux_cfg.no_crc_rx = aux_q[`NO_CRC_BIT];
    aux_cfg.crc_to_fifo = aux_q[`CRC_FIFO_BIT];
    aux_cfg.modulation_type_sel = aux_q[`MOD_AM_BIT];
    aux_cfg.field_detector_enable = aux_q[`FD_EN_BIT];
    aux_cfg.driver_hiz_during_ook = aux_q[`OOK_HIZ_BIT];
    aux_cfg.rx_tolerant = aux_q[`RX_TOL_BIT];
    aux_cfg.field_on_count = aux_q[`NFC_N_LSB +: 2];
  end

  // decoded subcarrier exponent, pulse count and tx period divider; unused codes give zero
  always_comb
  begin
    case ({ctx.bpsk_mode, stream_cfg.subcarrier_freq_sel})
      3'b000: subcarrier_div_log2 = 5'd6;
      3'b001: subcarrier_div_log2 = 5'd5;
      3'b010: subcarrier_div_log2 = 5'd4;
      3'b011: subcarrier_div_log2 = 5'd3;
      3'b100: subcarrier_div_log2 = 5'd4;
      3'b101: subcarrier_div_log2 = 5'd3;
      3'b110: subcarrier_div_log2 = 5'd2;
      default: subcarrier_div_log2 = 5'd0;
    endcase
    // single pulse only in bpsk
    if (stream_cfg.report_pulse_count == 2'b00 && !ctx.bpsk_mode)
      report_pulses = 4'd0;
    else
      report_pulses = 4'd1 << stream_cfg.report_pulse_count;
    if (stream_cfg.tx_period_sel == 3'b111)
      tx_period_div = 8'd0;
    else
      tx_period_div = 8'd128 >> stream_cfg.tx_period_sel;
  end

  // registered framing controls
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_skip_crc <= 1'b0;
      crc_to_fifo <= 1'b0;
      rf_output_driver_hiz <= 1'b0;
    end
    else if (clk_en)
    begin
      rx_skip_crc <= aux_cfg.no_crc_rx || ctx.auto_no_crc;
      crc_to_fifo <= aux_cfg.crc_to_fifo;
      rf_output_driver_hiz <= aux_cfg.driver_hiz_during_ook
        && ctx.ook_active && !aux_cfg.modulation_type_sel;
    end
  end

  // response held until taken
  bvalid_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bvalid && !bready |=> bvalid) else $error("bvalid dropped");
  // set-default restores tolerance bit
  default_aux_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && set_default |=> aux_q == 8'h04)
    else $error("aux default wrong");
  default_stream_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && set_default |=> stream_q == 8'h00)
    else $error("stream default wrong");
  skip_crc_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && (aux_q[7] || ctx.auto_no_crc) |=> rx_skip_crc)
    else $error("crc not skipped");
  auto_crc_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && ctx.auto_no_crc && !aux_q[7] |=> rx_skip_crc)
    else $error("auto no crc missed");
  crc_fifo_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en |=> crc_to_fifo == $past(aux_q[6]))
    else $error("crc to fifo wrong");
  preset_am_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && analog_preset && !set_default && !wr_fire
    |=> aux_q[5] == $past(preset_am)) else $error("preset lost");
  hiz_am_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && aux_q[5] |=> !rf_output_driver_hiz)
    else $error("hiz in am");
  tx_div_a: assert property (@(posedge aclk) disable iff (!aresetn)
    stream_q[2:0] == 3'b000 |-> tx_period_div == 8'd128)
    else $error("tx div wrong");
  pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
    stream_q[4:3] == 2'b11 |-> report_pulses == 4'd8)
    else $error("pulse count wrong");
  sc_div_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctx.bpsk_mode && stream_q[6:5] == 2'b00 |-> subcarrier_div_log2 == 5'd6)
    else $error("subcarrier div wrong");
  // read response held until taken
  rvalid_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid && !rready |=> rvalid) else $error("rvalid dropped");
  // read data stable while pending
  rdata_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid && !rready |=> $stable(rdata))
    else $error("rdata changed");
  // reserved stream bit stays zero
  stream_bit7_a: assert property (@(posedge aclk) disable iff (!aresetn)
    stream_q[7] == 1'b0) else $error("stream bit7 set");
  // low clock enable freezes both registers
  freeze_stream_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !clk_en |=> $stable(stream_q)) else $error("stream moved");
  freeze_aux_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !clk_en |=> $stable(aux_q)) else $error("aux moved");
  // no handshake accepted while frozen
  ready_freeze_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !clk_en |-> !awready && !wready && !arready)
    else $error("ready while frozen");
  // cleared byte strobe leaves registers alone
  strobe_mask_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && wr_fire && !wr_strb0 && !set_default && !analog_preset
    |=> $stable(aux_q) && $stable(stream_q))
    else $error("masked write landed");
  // tolerance bit back to one after set-default
  tol_default_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && set_default |=> aux_cfg.rx_tolerant)
    else $error("tolerance not set");
  // aux write lands whole, field-on count included
  aux_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && wr_fire && wr_strb0 && wr_addr == `AUX_DEF_ADDR
    && !set_default |=> aux_q == $past(wr_data[7:0]))
    else $error("aux write lost");
  // detector enable follows the written bit
  fd_view_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && wr_fire && wr_strb0 && wr_addr == `AUX_DEF_ADDR
    && !set_default |=> aux_cfg.field_detector_enable == $past(wr_data[4]))
    else $error("detector enable wrong");
  // driver goes high impedance in ook when asked
  hiz_ook_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && aux_q[3] && ctx.ook_active && !aux_q[5]
    |=> rf_output_driver_hiz) else $error("hiz missing");
  // single pulse refused outside bpsk
  pulse_single_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctx.bpsk_mode && stream_q[4:3] == 2'b00 |-> report_pulses == 4'd0)
    else $error("single pulse outside bpsk");
  // unused period code gives zero
  tx_unused_a: assert property (@(posedge aclk) disable iff (!aresetn)
    stream_q[2:0] == 3'b111 |-> tx_period_div == 8'd0)
    else $error("unused period decoded");
endmodule : stream_aux_framing_config

// ---- hdl/stream_aux_framing_map.svh ----
// register map, field positions and reset values of the framing config bank
// assumes inclusion by the bank module only
//
// Function
// - subcarrier frequency code, meaning per subcarrier or bpsk mode
// - two-bit pulse count code gives 1, 2, 4 or 8 pulses, single only bpsk
// - three-bit tx modulator period code, fc/128 down to fc/2, 111 unused
// - both registers default at power-up and set-default; tolerance bit is one
// - bit 7 set: receive every protocol without crc check
// - reqa, wupa and anticollision receive without crc regardless of bit 7
// - bit 6 set: crc still checked, crc bytes go to fifo and count
// - bit 5 selects ook or am; set by analog preset, changed by writes
// - bit 4 enables external field detector with peer threshold
// - bit 3 puts rf output driver in high impedance during ook
// - tolerance bit enables tolerant bpsk decoder and first-byte processing
// - bits 1..0 give n for the field-on nfc direct commands
`ifndef STREAM_AUX_FRAMING_MAP_SVH
`define STREAM_AUX_FRAMING_MAP_SVH
`define STREAM_MODE_OFFSET 8'h08
`define AUX_DEF_OFFSET 8'h09
// byte addresses on the bus are four times the register index
`define STREAM_MODE_ADDR 8'h20
`define AUX_DEF_ADDR 8'h24
`define STREAM_MODE_RESET 8'h00
`define AUX_DEF_RESET 8'h04
`define SCF_LSB 5
`define SCP_LSB 3
`define STX_LSB 0
`define NO_CRC_BIT 7
`define CRC_FIFO_BIT 6
`define MOD_AM_BIT 5
`define FD_EN_BIT 4
`define OOK_HIZ_BIT 3
`define RX_TOL_BIT 2
`define NFC_N_LSB 0
`endif

// ---- hdl/stream_aux_framing_pkg.sv ----
// types shared by the framing config bank
// assumes the map header sits beside it
package stream_aux_framing_pkg;
  typedef enum logic [1:0] {resp_okay = 2'b00, resp_slverr = 2'b10} resp_type;
  typedef struct packed {
    logic [1:0] subcarrier_freq_sel;
    logic [1:0] report_pulse_count;
    logic [2:0] tx_period_sel;
  } stream_cfg_type;
  typedef struct packed {
    logic no_crc_rx;
    logic crc_to_fifo;
    logic modulation_type_sel;
    logic field_detector_enable;
    logic driver_hiz_during_ook;
    logic rx_tolerant;
    logic [1:0] field_on_count;
  } aux_cfg_type;
  typedef struct packed {
    logic bpsk_mode;
    logic auto_no_crc;
    logic ook_active;
  } framing_ctx_type;
endpackage : stream_aux_framing_pkg

// ---- tb/stream_aux_framing_config_tb.sv ----
// self-checking bench for the framing config register bank
// assumes the bank, its package and map header are compiled before it
`timescale 1ns/1ps
module stream_aux_framing_config_tb
  import stream_aux_framing_pkg::*;
;
  logic aclk, aresetn, clk_en, set_default, analog_preset, preset_am;
  framing_ctx_type ctx;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rdata_s;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, bresp_s, rresp_s;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  stream_cfg_type stream_cfg;
  aux_cfg_type aux_cfg;
  logic [4:0] subcarrier_div_log2;
  logic [3:0] report_pulses;
  logic [7:0] tx_period_div;
  logic rx_skip_crc, crc_to_fifo, rf_output_driver_hiz;
  int n_errors = 0;
  int comparisons = 0;

  stream_aux_framing_config uut (
    .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .set_default(set_default), .analog_preset(analog_preset),
    .preset_am(preset_am), .ctx(ctx), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .stream_cfg(stream_cfg), .aux_cfg(aux_cfg),
    .subcarrier_div_log2(subcarrier_div_log2),
    .report_pulses(report_pulses), .tx_period_div(tx_period_div),
    .rx_skip_crc(rx_skip_crc), .crc_to_fifo(crc_to_fifo),
    .rf_output_driver_hiz(rf_output_driver_hiz)
  );

  // 200 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // closing report and end of run
  task print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  // mid-cycle sample of what the next rising edge will see
  task automatic wait_edge(output logic aw, w, b, ar, r);
    @(negedge aclk);
    aw = awvalid && awready;
    w = wvalid && wready;
    b = bvalid && bready;
    ar = arvalid && arready;
    r = rvalid && rready;
    bresp_s = bresp;
    rresp_s = rresp;
    rdata_s = rdata;
    @(posedge aclk);
  endtask : wait_edge

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           input logic [3:0] s, input logic [1:0] er);
    int i;
    logic aw, w, b, ar, r;
    awaddr <= a; wdata <= d; wstrb <= s;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (i = 0; i < 40; i++)
    begin
      wait_edge(aw, w, b, ar, r);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) break;
    end
    bready <= 1'b0;
    if (i == 40) begin n_errors++; print_verdict; end
    check(32'(bresp_s), 32'(er));
    @(posedge aclk);
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, input logic [31:0] ed,
                          input logic [1:0] er);
    int i;
    logic aw, w, b, ar, r;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (i = 0; i < 40; i++)
    begin
      wait_edge(aw, w, b, ar, r);
      if (ar) arvalid <= 1'b0;
      if (r) break;
    end
    rready <= 1'b0;
    if (i == 40) begin n_errors++; print_verdict; end
    check(rdata_s, ed);
    check(32'(rresp_s), 32'(er));
    @(posedge aclk);
  endtask : axi_read

  // wait three clock edges for the outputs to settle
  task automatic settle;
    repeat (3) @(posedge aclk);
  endtask : settle

  // main sequence
  initial
  begin
    int bm, k;
    logic [1:0] f, p;
    logic [2:0] t;
    aresetn = 1'b0; clk_en = 1'b1; set_default = 1'b0;
    analog_preset = 1'b0; preset_am = 1'b0; ctx = '0;
    awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'h0;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_read(8'h20, 32'h0, 2'h0);
    axi_read(8'h24, 32'h4, 2'h0);
    check(32'(tx_period_div), 32'h80);
    $display("test reset done");
    // period codes 000 to 110 with matching frequency and pulse codes in both stream modes
    for (bm = 0; bm < 2; bm++)
    begin
      for (k = 0; k < 7; k++)
      begin
        t = 3'(k);
        f = (bm == 1 && t[1:0] == 2'h3) ? 2'h2 : t[1:0];
        p = f + 2'h1;
        ctx.bpsk_mode <= bm[0];
        axi_write(8'h20, {25'h0, f, p, t}, 4'hf, 2'h0);
        settle;
        check(32'(tx_period_div), t == 3'h7 ? 32'h0 : 32'h80 >> t);
        check(32'(subcarrier_div_log2), bm == 1 ? (f == 2'h3 ? 32'h0 :
          32'h4 - f) : 32'h6 - f);
        check(32'(report_pulses), (p == 2'h0 && bm == 0) ? 32'h0 :
          32'h1 << p);
        check(32'(stream_cfg), {25'h0, f, p, t});
        axi_read(8'h20, {25'h0, f, p, t}, 2'h0);
      end
    end
    axi_write(8'h20, 32'hffff_ffff, 4'h0, 2'h0);
    axi_read(8'h20, 32'h5e, 2'h0);
    axi_write(8'h20, 32'hff, 4'hf, 2'h0);
    axi_read(8'h20, 32'h7f, 2'h0);
    $display("test stream codes done");
    // auxiliary bits and their effects
    ctx <= '0;
    axi_write(8'h24, 32'hdb, 4'hf, 2'h0);
    ctx.ook_active <= 1'b1;
    settle;
    check(32'(rx_skip_crc), 32'h1);
    check(32'(crc_to_fifo), 32'h1);
    check(32'(aux_cfg), 32'hdb);
    check(32'(rf_output_driver_hiz), 32'h1);
    axi_write(8'h24, 32'h2c, 4'hf, 2'h0);
    settle;
    check(32'(rf_output_driver_hiz), 32'h0);
    check(32'(rx_skip_crc), 32'h0);
    check(32'(aux_cfg), 32'h2c);
    ctx.auto_no_crc <= 1'b1;
    settle;
    check(32'(rx_skip_crc), 32'h1);
    analog_preset <= 1'b1;
    @(posedge aclk);
    analog_preset <= 1'b0;
    settle;
    axi_read(8'h24, 32'h0c, 2'h0);
    axi_write(8'h24, 32'h03, 4'hf, 2'h0);
    axi_read(8'h24, 32'h03, 2'h0);
    $display("test auxiliary done");
    // set-default and unmapped accesses
    set_default <= 1'b1;
    @(posedge aclk);
    set_default <= 1'b0;
    settle;
    axi_read(8'h20, 32'h0, 2'h0);
    axi_read(8'h24, 32'h4, 2'h0);
    axi_write(8'h40, 32'hff, 4'hf, 2'h2);
    axi_read(8'h40, 32'h0, 2'h2);
    $display("test defaults and unmapped done");
    print_verdict;
  end
endmodule : stream_aux_framing_config_tb
